// ---- src/nvc_cfg.svh ----
/*
  timing and address constants for the nvsram store/recall host controller.
  assumes a 50 MHz system clock; included by bare name.
*/
`ifndef NVC_CFG_SVH
`define NVC_CFG_SVH

`define NVC_CLK_NS 20
// host-side timing, in ns, us or ms as named
`define NVC_T_CYCLE_NS 45
`define NVC_T_HSB_PULSE_NS 15
`define NVC_T_RECOVER_NS 700
`define NVC_T_BUSY_NS 300
`define NVC_T_RECALL_US 20
`define NVC_T_STORE_MS 10
`define NVC_T_RESTORE_US 550
// derived cycle counts (least times round up)
`define NVC_CYC_ACCESS ((`NVC_T_CYCLE_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_CYC_HSB ((`NVC_T_HSB_PULSE_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_CYC_BUSY ((`NVC_T_BUSY_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_CYC_RECOVER ((`NVC_T_RECOVER_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_CYC_RECALL ((`NVC_T_RECALL_US * 1000) / `NVC_CLK_NS)
`define NVC_CYC_STORE ((`NVC_T_STORE_MS * 1000000) / `NVC_CLK_NS)
`define NVC_CYC_RESTORE ((`NVC_T_RESTORE_US * 1000) / `NVC_CLK_NS)
// software sequence addresses, low 14 bits
`define NVC_SEQ_A0 14'h0E38
`define NVC_SEQ_A1 14'h31C7
`define NVC_SEQ_A2 14'h03E0
`define NVC_SEQ_A3 14'h3C1F
`define NVC_SEQ_A4 14'h303F
`define NVC_SEQ_STORE 14'h0FC0
`define NVC_SEQ_RECALL 14'h0C63
`define NVC_SEQ_LEN 3'h6

`endif

// ---- src/nvc_pkg.sv ----
/*
  types for the nvsram host controller.
  assumes nothing beyond the compile order.
*/
package nvc_pkg;
  typedef enum logic [3:0] {
    NVC_IDLE = 4'h0,
    NVC_SETUP = 4'h1,
    NVC_STROBE = 4'h2,
    NVC_HOLD = 4'h3,
    NVC_HSB_LOW = 4'h4,
    NVC_HSB_WAIT = 4'h5,
    NVC_HSB_REL = 4'h6,
    NVC_RECOVER = 4'h7,
    NVC_NV_WAIT = 4'h8,
    NVC_DONE = 4'h9
  } nvc_state_t;

  typedef enum logic [1:0] {
    NVC_OP_READ = 2'h0,
    NVC_OP_WRITE = 2'h1,
    NVC_OP_SWSEQ = 2'h2,
    NVC_OP_HWSTORE = 2'h3
  } nvc_op_t;
endpackage : nvc_pkg

// ---- src/nvc_seq_rom.sv ----
/*
  small registered table of the six software sequence addresses.
  assumes index below six; entry five depends on store or recall.
*/
`timescale 1ns/1ns
`include "nvc_cfg.svh"
module nvc_seq_rom (
  // clock
  input wire logic clock_in,
  // lookup
  input wire logic [2:0] index_in,
  input wire logic recall_in,
  output logic [13:0] addr_out
);
  logic [13:0] addr_next;
  assign addr_next = (index_in == 3'h0) ? `NVC_SEQ_A0 :
                     (index_in == 3'h1) ? `NVC_SEQ_A1 :
                     (index_in == 3'h2) ? `NVC_SEQ_A2 :
                     (index_in == 3'h3) ? `NVC_SEQ_A3 :
                     (index_in == 3'h4) ? `NVC_SEQ_A4 :
                     (recall_in ? `NVC_SEQ_RECALL : `NVC_SEQ_STORE);
  always_ff @(posedge clock_in) begin
    addr_out <= addr_next;
  end
endmodule : nvc_seq_rom

// ---- src/nvc_host.sv ----
/*
  host controller that drives an nvsram through its parallel pins:
  reads, writes, software store/recall sequences and hardware store.
  assumes pins synchronous to clock_in and a device that keeps its own rules.
*/
// Function
// RULE1: device reads with select and gate low, strobe and store/busy high.
// RULE2: device writes with select and strobe low, store/busy high.
// RULE3: select high with store/busy high means standby, outputs float.
// RULE4: store/busy low forces nonvolatile store mode, outputs float.
// RULE5: strobe low before select falls keeps device outputs floating.
// RULE6: host keeps store/busy high through every write cycle.
// RULE7: hardware store copies only if a write occurred since last cycle.
// RULE8: after hardware store, device blocks until store/busy rises again.
// RULE9: device lets a running cycle finish at least one microsecond.
// RULE10: inhibit lifts within 700 ns after store/busy rises post store.
// RULE11: host holds hardware store request low at least 15 ns.
// RULE12: device drives store/busy low as busy within 300 ns.
// RULE13: power fail drives store/busy low within 300 ns for 1 us.
// RULE14: power fail without writes releases store/busy and skips store.
// RULE15: power-up recall completes within 550 us of supply rising.
// RULE16: software cycle starts only after six ordered read accesses.
// RULE17: store sequence ends with 0FC0, sixth access leaves outputs floating.
// RULE18: recall sequence ends with 0C63, lasting at most 20 us.
// RULE19: host keeps write strobe high during all six sequence accesses.
// RULE20: only the low 14 address bits are compared.
// RULE21: recognition ignores output gate; only data output follows it.
// RULE22: sequence accesses are select-timed reads, address latched at fall.
// RULE23: any other access inside the sequence aborts it.
// RULE24: after software store starts, all access waits until it completes.
`timescale 1ns/1ns
`include "nvc_cfg.svh"
module nvc_host #(
  parameter int ADDR_W = 15,
  parameter int DATA_W = 8,
  parameter int STORE_CYC = `NVC_CYC_STORE,
  parameter int RESTORE_CYC = `NVC_CYC_RESTORE,
  parameter int RECALL_CYC = `NVC_CYC_RECALL
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // user command port
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_op_in,
  input wire logic cmd_recall_in,
  input wire logic [ADDR_W-1:0] cmd_addr_in,
  input wire logic [DATA_W-1:0] cmd_wdata_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [DATA_W-1:0] rsp_rdata_out,
  // memory pins
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic mem_sel_n_out,
  output logic mem_wr_n_out,
  output logic mem_gate_n_out,
  input wire logic [DATA_W-1:0] mem_dq_in,
  output logic [DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe_out,
  input wire logic hw_store_busy_n_in,
  output logic hw_store_busy_n_out,
  output logic hw_store_busy_n_oe_out
);
  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] CYC_ACCESS = CNT_W'(`NVC_CYC_ACCESS);
  localparam logic [CNT_W-1:0] CYC_HSB = CNT_W'(`NVC_CYC_HSB);
  localparam logic [CNT_W-1:0] CYC_BUSY = CNT_W'(`NVC_CYC_BUSY);
  localparam logic [CNT_W-1:0] CYC_RECOVER = CNT_W'(`NVC_CYC_RECOVER);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  nvc_pkg::nvc_state_t state_reg, state_next;
  nvc_pkg::nvc_op_t op_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [2:0] seq_idx_reg;
  logic recall_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic boot_reg;
  logic [13:0] seq_addr;
  // look one access ahead so the table word is ready when the address loads
  wire [2:0] rom_idx = (state_reg == nvc_pkg::NVC_SETUP || state_reg == nvc_pkg::NVC_STROBE ||
                        state_reg == nvc_pkg::NVC_HOLD) ? seq_idx_reg + 3'h1 : 3'h0;

  nvc_seq_rom u_rom (
    .clock_in(clock_in),
    .index_in(rom_idx),
    .recall_in(recall_reg),
    .addr_out(seq_addr)
  );

  wire cnt_done = (cnt_reg <= CNT_W'(1));
  // a command is taken only on an edge where ready stands high
  wire take_cmd = (state_reg == nvc_pkg::NVC_IDLE) && cmd_valid_in && cmd_ready_out &&
                  !boot_reg;
  wire is_write = (op_reg == nvc_pkg::NVC_OP_WRITE);
  wire is_seq = (op_reg == nvc_pkg::NVC_OP_SWSEQ);
  wire seq_last = (seq_idx_reg == (`NVC_SEQ_LEN - 3'h1));

  // ------------------------------------------------------------
  // next state decode
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      nvc_pkg::NVC_IDLE: begin
        if (take_cmd) begin
          state_next = (cmd_op_in == nvc_pkg::NVC_OP_HWSTORE) ?
                       nvc_pkg::NVC_HSB_LOW : nvc_pkg::NVC_SETUP;
        end
      end
      nvc_pkg::NVC_SETUP: state_next = nvc_pkg::NVC_STROBE;
      nvc_pkg::NVC_STROBE: begin
        if (cnt_done) begin
          state_next = nvc_pkg::NVC_HOLD;
        end
      end
      nvc_pkg::NVC_HOLD: begin
        if (is_seq && !seq_last) begin
          state_next = nvc_pkg::NVC_SETUP;
        end else if (is_seq) begin
          state_next = nvc_pkg::NVC_NV_WAIT;
        end else begin
          state_next = nvc_pkg::NVC_DONE;
        end
      end
      nvc_pkg::NVC_HSB_LOW: begin
        if (cnt_done) begin
          state_next = nvc_pkg::NVC_HSB_WAIT;
        end
      end
      nvc_pkg::NVC_HSB_WAIT: begin
        if (hw_store_busy_n_in || cnt_done) begin
          state_next = nvc_pkg::NVC_HSB_REL;
        end
      end
      nvc_pkg::NVC_HSB_REL: begin
        if (hw_store_busy_n_in) begin
          state_next = nvc_pkg::NVC_RECOVER;
        end
      end
      nvc_pkg::NVC_RECOVER, nvc_pkg::NVC_NV_WAIT: begin
        if (cnt_done) begin
          state_next = nvc_pkg::NVC_DONE;
        end
      end
      nvc_pkg::NVC_DONE: state_next = nvc_pkg::NVC_IDLE;
      default: state_next = nvc_pkg::NVC_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // sequencer registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_reg <= nvc_pkg::NVC_IDLE;
      op_reg <= nvc_pkg::NVC_OP_READ;
      cnt_reg <= RESTORE_CYC;
      boot_reg <= 1'b1;
      seq_idx_reg <= 3'h0;
      recall_reg <= 1'b0;
      wdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      // RULE15 wait for power-up recall
      if (boot_reg) begin
        cnt_reg <= cnt_reg - CNT_W'(1);
        if (cnt_done) begin
          boot_reg <= 1'b0;
        end
      end else if (take_cmd) begin
        op_reg <= nvc_pkg::nvc_op_t'(cmd_op_in);
        recall_reg <= cmd_recall_in;
        wdata_reg <= cmd_wdata_in;
        seq_idx_reg <= 3'h0;
        // RULE11 minimum store request width
        cnt_reg <= (cmd_op_in == nvc_pkg::NVC_OP_HWSTORE) ? CYC_HSB : CYC_ACCESS;
      end else if (state_reg == nvc_pkg::NVC_HSB_LOW && cnt_done) begin
        // RULE12 busy must appear within bound
        cnt_reg <= CYC_BUSY + CNT_W'(STORE_CYC);
      end else if (state_reg == nvc_pkg::NVC_HSB_REL && hw_store_busy_n_in) begin
        // RULE10 recovery before next access
        cnt_reg <= CYC_RECOVER;
      end else if (state_reg == nvc_pkg::NVC_HOLD) begin
        // RULE18 wait out recall or store
        cnt_reg <= is_seq && seq_last ?
                   (recall_reg ? CNT_W'(RECALL_CYC) : CNT_W'(STORE_CYC)) : CYC_ACCESS;
        seq_idx_reg <= seq_idx_reg + 3'h1;
      end else if (!cnt_done) begin
        cnt_reg <= cnt_reg - CNT_W'(1);
      end
    end
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  wire in_access = (state_reg == nvc_pkg::NVC_SETUP) || (state_reg == nvc_pkg::NVC_STROBE) ||
                   (state_reg == nvc_pkg::NVC_HOLD);
  // RULE22 address set one cycle before select falls
  wire load_addr = take_cmd || (state_reg == nvc_pkg::NVC_HOLD && is_seq && !seq_last);
  wire load_seq = take_cmd ? (cmd_op_in == nvc_pkg::NVC_OP_SWSEQ) : is_seq;
  wire [ADDR_W-1:0] addr_next = !load_addr ? mem_addr_out :
                                (load_seq ? {{(ADDR_W-14){1'b0}}, seq_addr} : cmd_addr_in);
  wire sel_n_next = !(state_next == nvc_pkg::NVC_STROBE);
  // RULE19 strobe stays high for sequence reads
  wire wr_n_next = !(state_next == nvc_pkg::NVC_STROBE && is_write);
  wire gate_n_next = !(state_next == nvc_pkg::NVC_STROBE && op_reg == nvc_pkg::NVC_OP_READ);
  // RULE6 store/busy released except for a store request
  wire hsb_drive_next = (state_next == nvc_pkg::NVC_HSB_LOW);
  wire capture = (state_reg == nvc_pkg::NVC_STROBE) && cnt_done &&
                 (op_reg == nvc_pkg::NVC_OP_READ);

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      mem_addr_out <= '0;
      mem_sel_n_out <= 1'b1;
      mem_wr_n_out <= 1'b1;
      mem_gate_n_out <= 1'b1;
      mem_dq_out <= '0;
      mem_dq_oe_out <= 1'b0;
      hw_store_busy_n_out <= 1'b1;
      hw_store_busy_n_oe_out <= 1'b0;
      cmd_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end else begin
      mem_addr_out <= addr_next;
      mem_sel_n_out <= sel_n_next;
      mem_wr_n_out <= wr_n_next;
      mem_gate_n_out <= gate_n_next;
      mem_dq_out <= wdata_reg;
      mem_dq_oe_out <= in_access && is_write && state_next != nvc_pkg::NVC_DONE;
      hw_store_busy_n_out <= 1'b0;
      hw_store_busy_n_oe_out <= hsb_drive_next;
      cmd_ready_out <= (state_next == nvc_pkg::NVC_IDLE) && !boot_reg && !take_cmd;
      rsp_valid_out <= (state_reg == nvc_pkg::NVC_DONE);
      if (capture) begin
        rsp_rdata_out <= mem_dq_in;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  hsb_write_high_a: assert property (!mem_wr_n_out |-> !hw_store_busy_n_oe_out) // RULE6
    else $error("store/busy driven during write");
  hsb_pulse_min_a: assert property ($rose(hw_store_busy_n_oe_out) |-> // RULE11
    cnt_reg >= CYC_HSB && !hw_store_busy_n_out)
    else $error("store request pulse too short");
  seq_wr_high_a: assert property (is_seq && !mem_sel_n_out |-> mem_wr_n_out) // RULE19
    else $error("strobe low in sequence");
  seq_addr_stable_a: assert property ($fell(mem_sel_n_out) |-> $stable(mem_addr_out)) // RULE22
    else $error("address moved as select fell");
  seq_addr_14_a: assert property (is_seq && !mem_sel_n_out |-> mem_addr_out[ADDR_W-1] == 1'b0) // RULE20
    else $error("sequence top bit set");
  boot_block_a: assert property (boot_reg |-> mem_sel_n_out && !cmd_ready_out) // RULE15
    else $error("access during power-up recall");
  nv_wait_idle_a: assert property (state_reg == nvc_pkg::NVC_NV_WAIT |-> mem_sel_n_out) // RULE24
    else $error("access during software cycle");
  recover_quiet_a: assert property (hw_store_busy_n_in && state_reg == nvc_pkg::NVC_HSB_REL // RULE10
    |=> mem_sel_n_out [*8])
    else $error("access inside recovery");
  wr_gate_a: assert property (!mem_wr_n_out |-> mem_gate_n_out && mem_dq_oe_out) // RULE2
    else $error("write with gate low");

  rd_cov: cover property (rsp_valid_out && op_reg == nvc_pkg::NVC_OP_READ);
  wr_cov: cover property (rsp_valid_out && is_write);
  seq_cov: cover property (state_reg == nvc_pkg::NVC_NV_WAIT && recall_reg);
  hw_cov: cover property (state_reg == nvc_pkg::NVC_RECOVER);
endmodule : nvc_host

// ---- verif/nvc_dev_model.sv ----
/*
  behavioural model of the nvsram seen from its pins.
  assumes pins sampled on clock_in; the bench resolves the shared wires.
*/
`timescale 1ns/1ns
module nvc_dev_model #(
  parameter int NV_CYC = 15,
  parameter int PF_CYC = 50
) (
  // clock
  input wire logic clock_in,
  // sram pins
  input wire logic [14:0] addr_in,
  input wire logic sel_n_in,
  input wire logic wr_n_in,
  input wire logic gate_n_in,
  input wire logic [7:0] dq_in,
  input wire logic hsb_in,
  // supply falling through the power-fail threshold
  input wire logic pfail_in,
  output logic [7:0] dq_out,
  output logic dq_oe_out,
  output logic hsb_pull_out = 1'b0
);
  logic [7:0] sram [32768];
  logic [7:0] nv [32768];
  logic [13:0] seq_tab [5] = '{14'h0E38, 14'h31C7, 14'h03E0, 14'h3C1F, 14'h303F};
  logic written_reg = 1'b0;
  logic sel_prev_reg = 1'b1;
  logic [2:0] idx_reg = 3'h0;
  int busy_reg = 0;
  wire [13:0] low_addr = addr_in[13:0];
  assign dq_oe_out = (busy_reg == 0) && (sel_n_in === 1'b0) && (gate_n_in === 1'b0) &&
                     (wr_n_in === 1'b1) && (hsb_in === 1'b1);
  assign dq_out = sram[addr_in];
  always @(posedge clock_in) begin
    sel_prev_reg <= sel_n_in;
    if (busy_reg > 0) begin
      busy_reg <= busy_reg - 1;
      if (busy_reg == 1) hsb_pull_out <= 1'b0;
    end else if (pfail_in === 1'b1) begin
      // busy pulse on power fail, store only if written
      if (written_reg) nv = sram;
      written_reg <= 1'b0;
      hsb_pull_out <= 1'b1;
      busy_reg <= PF_CYC;
      idx_reg <= 3'h0;
    end else if (hsb_in === 1'b0) begin
      if (written_reg) begin
        nv = sram;
        written_reg <= 1'b0;
        hsb_pull_out <= 1'b1;
        busy_reg <= NV_CYC;
      end
      idx_reg <= 3'h0;
    end else begin
      if (sel_n_in === 1'b0 && wr_n_in === 1'b0) begin
        sram[addr_in] = dq_in;
        written_reg <= 1'b1;
      end
      if (sel_prev_reg === 1'b1 && sel_n_in === 1'b0) begin
        if (wr_n_in !== 1'b1) idx_reg <= 3'h0;
        else if (idx_reg == 3'h5 && low_addr == 14'h0FC0) begin
          nv = sram;
          written_reg <= 1'b0;
          busy_reg <= NV_CYC;
          idx_reg <= 3'h0;
        end else if (idx_reg == 3'h5 && low_addr == 14'h0C63) begin
          sram = nv;
          written_reg <= 1'b0;
          busy_reg <= NV_CYC / 2;
          idx_reg <= 3'h0;
        end else if (idx_reg < 3'h5 && low_addr == seq_tab[idx_reg]) idx_reg <= idx_reg + 3'h1;
        else if (low_addr == seq_tab[0]) idx_reg <= 3'h1;
        else idx_reg <= 3'h0;
      end
    end
  end
endmodule : nvc_dev_model

// ---- verif/nvc_host_test.sv ----
/*
  self-checking bench for the nvsram host controller with a device model.
  assumes short store, restore and recall counts set below.
*/
`timescale 1ns/1ns
module nvc_host_test;
  localparam int SHORT_N = 20;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  logic [1:0] cmd_op_in = 2'h0;
  logic cmd_recall_in = 1'b0;
  logic [14:0] cmd_addr_in = 15'h0000;
  logic [7:0] cmd_wdata_in = 8'h00;
  logic cmd_ready_out, rsp_valid_out, mem_sel_n_out, mem_wr_n_out, mem_gate_n_out;
  logic mem_dq_oe_out, hsb_drv, hsb_oe, dev_oe, dev_pull, hsb_pin;
  logic [7:0] rsp_rdata_out, mem_dq_out, dev_dq, dq_bus, rd;
  logic [7:0] dq_last = 8'h00;
  logic [14:0] mem_addr_out;
  logic in_seq = 1'b0;
  logic pfail = 1'b0;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  int low_cnt = 0;
  int n;

  assign hsb_pin = ((hsb_oe && !hsb_drv) || dev_pull) ? 1'b0 : 1'b1;
  assign dq_bus = mem_dq_oe_out ? mem_dq_out : (dev_oe ? dev_dq : ~dq_last);

  nvc_host #(.STORE_CYC(SHORT_N), .RESTORE_CYC(SHORT_N), .RECALL_CYC(SHORT_N)) uut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .cmd_valid_in(cmd_valid_in),
    .cmd_op_in(cmd_op_in), .cmd_recall_in(cmd_recall_in), .cmd_addr_in(cmd_addr_in),
    .cmd_wdata_in(cmd_wdata_in), .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_rdata_out(rsp_rdata_out), .mem_addr_out(mem_addr_out), .mem_sel_n_out(mem_sel_n_out),
    .mem_wr_n_out(mem_wr_n_out), .mem_gate_n_out(mem_gate_n_out), .mem_dq_in(dq_bus),
    .mem_dq_out(mem_dq_out), .mem_dq_oe_out(mem_dq_oe_out), .hw_store_busy_n_in(hsb_pin),
    .hw_store_busy_n_out(hsb_drv), .hw_store_busy_n_oe_out(hsb_oe));

  nvc_dev_model dev (
    .clock_in(clock_in), .addr_in(mem_addr_out), .sel_n_in(mem_sel_n_out),
    .wr_n_in(mem_wr_n_out), .gate_n_in(mem_gate_n_out), .dq_in(dq_bus), .hsb_in(hsb_pin),
    .pfail_in(pfail), .dq_out(dev_dq), .dq_oe_out(dev_oe), .hsb_pull_out(dev_pull));

  // undriven data lines show the inverse of the last driven byte
  always @(posedge clock_in) begin
    if (mem_dq_oe_out || dev_oe) dq_last <= dq_bus;
  end

  initial forever #10 clock_in = ~clock_in;

  // ----------------------------------------
  // shared tasks and pin monitor
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task automatic do_cmd(input logic [1:0] op, input logic rc, input logic [14:0] a,
                        input logic [7:0] d);
    int k;
    k = 0;
    cmd_op_in <= op;
    cmd_recall_in <= rc;
    cmd_addr_in <= a;
    cmd_wdata_in <= d;
    cmd_valid_in <= 1'b1;
    do begin
      @(posedge clock_in);
      k++;
    end while (cmd_ready_out !== 1'b1 && k < 500);
    cmd_valid_in <= 1'b0;
    do begin
      @(posedge clock_in);
      k++;
    end while (rsp_valid_out !== 1'b1 && k < 2000);
    chk({7'h00, rsp_valid_out}, 8'h01);
    rd = rsp_rdata_out;
  endtask : do_cmd

  always @(negedge clock_in) begin
    if (hsb_pin === 1'b0) low_cnt++;
    if (hsb_pin === 1'b0) chk({7'h00, mem_sel_n_out}, 8'h01);
    if (mem_sel_n_out === 1'b0 && mem_wr_n_out === 1'b0) chk({7'h00, hsb_pin}, 8'h01);
    if (in_seq && mem_sel_n_out === 1'b0) chk({7'h00, mem_wr_n_out}, 8'h01);
  end

  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      n_fail++;
      final_report();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_rw;
    do_cmd(2'h1, 1'b0, 15'h4123, 8'h5A);
    do_cmd(2'h1, 1'b0, 15'h0123, 8'hA5);
    do_cmd(2'h0, 1'b0, 15'h4123, 8'h00);
    chk(rd, 8'h5A);
    do_cmd(2'h0, 1'b0, 15'h0123, 8'h00);
    chk(rd, 8'hA5);
    $display("test rw done");
  endtask : t_rw

  task automatic t_hw;
    low_cnt = 0;
    do_cmd(2'h3, 1'b0, 15'h0000, 8'h00);
    chk({7'h00, low_cnt > 1}, 8'h01);
    do_cmd(2'h1, 1'b0, 15'h0123, 8'h11);
    in_seq = 1'b1;
    do_cmd(2'h2, 1'b1, 15'h0000, 8'h00);
    in_seq = 1'b0;
    do_cmd(2'h0, 1'b0, 15'h0123, 8'h00);
    chk(rd, 8'hA5);
    low_cnt = 0;
    do_cmd(2'h3, 1'b0, 15'h0000, 8'h00);
    chk(low_cnt[7:0], 8'h01);
    $display("test hw store done");
  endtask : t_hw

  task automatic t_sw;
    do_cmd(2'h1, 1'b0, 15'h0123, 8'h33);
    in_seq = 1'b1;
    do_cmd(2'h2, 1'b0, 15'h0000, 8'h00);
    in_seq = 1'b0;
    do_cmd(2'h1, 1'b0, 15'h0123, 8'h44);
    in_seq = 1'b1;
    do_cmd(2'h2, 1'b1, 15'h0000, 8'h00);
    in_seq = 1'b0;
    do_cmd(2'h0, 1'b0, 15'h0123, 8'h00);
    chk(rd, 8'h33);
    do_cmd(2'h0, 1'b0, 15'h4123, 8'h00);
    chk(rd, 8'h5A);
    $display("test sw store recall done");
  endtask : t_sw

  task automatic t_pf;
    do_cmd(2'h1, 1'b0, 15'h0042, 8'h66);
    low_cnt = 0;
    pfail <= 1'b1;
    @(posedge clock_in);
    pfail <= 1'b0;
    repeat (60) @(posedge clock_in);
    chk(low_cnt[7:0], 8'h32);
    do_cmd(2'h1, 1'b0, 15'h0042, 8'h77);
    in_seq = 1'b1;
    do_cmd(2'h2, 1'b1, 15'h0000, 8'h00);
    in_seq = 1'b0;
    do_cmd(2'h0, 1'b0, 15'h0042, 8'h00);
    chk(rd, 8'h66);
    low_cnt = 0;
    pfail <= 1'b1;
    @(posedge clock_in);
    pfail <= 1'b0;
    repeat (60) @(posedge clock_in);
    chk(low_cnt[7:0], 8'h32);
    $display("test power fail done");
  endtask : t_pf

  initial begin
    repeat (6) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (cmd_ready_out !== 1'b1 && n < 1000);
    chk({7'h00, n >= SHORT_N}, 8'h01);
    $display("test boot done");
    t_rw();
    t_hw();
    t_sw();
    t_pf();
    final_report();
  end
endmodule : nvc_host_test
